/* psq_pkg.sv */
package psq_pkg;

    localparam int PSQ_WORD_W = 10;
    localparam int PSQ_ADDR_W = 6;
    localparam int PSQ_PAGE_W = 5;
    localparam int PSQ_ROM_AW = 12;
    localparam int PSQ_CYC_DIV = 4;
    localparam int PSQ_CHANS = 4;
    localparam int PSQ_DISC = 16;

    localparam logic [4:0] PSQ_PAGE_RST = 5'h00;
    localparam logic [5:0] PSQ_ADDR_RST = 6'h3F;
    localparam logic       PSQ_STATUS_RST = 1'h1;
    localparam logic       PSQ_LATCH_RST = 1'h1;

    // Command bit positions inside a fetched pattern word, and the region select bit of the pattern instruction.
    localparam int PSQ_CMD_LOW_BIT = 8;
    localparam int PSQ_CMD_HIGH_BIT = 9;
    localparam int PSQ_PAT_SEL_BIT = 2;

    // Opcode prefixes, matched against the top bits of the word.
    localparam logic [1:0] PSQ_OP_JUMP = 2'h3;
    localparam logic [4:0] PSQ_OP_PAGE = 5'h16;
    localparam logic [6:0] PSQ_OP_PAT = 7'h50;
    localparam logic [7:0] PSQ_OP_TBL = 8'hA2;
    localparam logic [7:0] PSQ_OP_CHAN = 8'hA4;
    localparam logic [8:0] PSQ_OP_DISC_Y = 9'h14A;
    localparam logic [6:0] PSQ_OP_DISC_N = 7'h53;

    // Successor of every in-page address state, indexed by the state.
    localparam logic [5:0] PSQ_PC_NEXT [64] = '{
        6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0B, 6'h0D, 6'h0F,
        6'h11, 6'h13, 6'h15, 6'h17, 6'h19, 6'h1B, 6'h1D, 6'h1F,
        6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h2A, 6'h2C, 6'h2E,
        6'h30, 6'h32, 6'h34, 6'h36, 6'h38, 6'h3A, 6'h3C, 6'h3F,
        6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E,
        6'h10, 6'h12, 6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C, 6'h1E,
        6'h21, 6'h23, 6'h25, 6'h27, 6'h29, 6'h2B, 6'h2D, 6'h2F,
        6'h31, 6'h33, 6'h35, 6'h37, 6'h39, 6'h3B, 6'h3D, 6'h3E
    };

    typedef enum logic [0:0] {
        PSQ_PH_FETCH = 1'b0,
        PSQ_PH_PAT   = 1'b1
    } psq_phase_t;

endpackage

/* psq_io_if.sv */
interface psq_io_if;
    logic       chan_we;
    logic [1:0] chan_sel;
    logic [3:0] chan_data;
    logic       pat_we;
    logic [7:0] pat_data;
    logic       disc_we;
    logic [3:0] disc_idx;
    logic       disc_val;

    modport ctl (output chan_we, chan_sel, chan_data, pat_we, pat_data,
                 output disc_we, disc_idx, disc_val);
    modport io (input chan_we, chan_sel, chan_data, pat_we, pat_data,
                input disc_we, disc_idx, disc_val);
endinterface

/* psq_pc_step.sv */
module psq_pc_step (
    input  wire logic [5:0] cur,   // present in-page address
    output logic      [5:0] nxt    // successor state
);
    assign nxt = psq_pkg::PSQ_PC_NEXT[cur];
endmodule

/* psq_io_latch.sv */
module psq_io_latch #(
    parameter int CHANS = psq_pkg::PSQ_CHANS,
    parameter int DISC  = psq_pkg::PSQ_DISC
) (
    input  wire logic              clk,        // core clock
    input  wire logic              resetn,     // sync reset, active low
    psq_io_if.io                   wr,         // write requests
    input  wire logic [4*CHANS-1:0] chan_in,   // nibble pin levels
    output logic      [4*CHANS-1:0] chan_out,  // nibble pin drive value
    output logic      [4*CHANS-1:0] chan_oe_n, // nibble drive enable
    output logic      [4*CHANS-1:0] chan_lvl,  // synchronised levels
    input  wire logic [DISC-1:0]    disc_in,   // discrete pin levels
    output logic      [DISC-1:0]    disc_out,  // discrete drive value
    output logic      [DISC-1:0]    disc_oe_n, // discrete drive enable
    output logic      [DISC-1:0]    disc_lvl   // synchronised levels
);
    logic [4*CHANS-1:0] chan_meta;
    logic [DISC-1:0]    disc_meta;

    if (CHANS != 4 || DISC != 16)
        $error("psq_io_latch serves four channels and 16 pins only");

    // Open drain: a latched 1 releases the pin so that it can be read.
    for (genvar c = 0; c < CHANS; c++)
    begin
        always_ff @(posedge clk)
        begin
            if (!resetn)
                chan_out[4*c +: 4] <= {4{psq_pkg::PSQ_LATCH_RST}};
            else if (wr.chan_we && wr.chan_sel == 2'(c))
                chan_out[4*c +: 4] <= wr.chan_data;
            else if (wr.pat_we && c == 2)
                chan_out[4*c +: 4] <= wr.pat_data[7:4];
            else if (wr.pat_we && c == 3)
                chan_out[4*c +: 4] <= wr.pat_data[3:0];
        end
    end

    for (genvar d = 0; d < DISC; d++)
    begin
        always_ff @(posedge clk)
        begin
            if (!resetn)
                disc_out[d] <= psq_pkg::PSQ_LATCH_RST;
            else if (wr.disc_we && wr.disc_idx == 4'(d))
                disc_out[d] <= wr.disc_val;
        end
    end

    assign chan_oe_n = chan_out;
    assign disc_oe_n = disc_out;

    always_ff @(posedge clk)
    begin
        chan_meta <= chan_in;
        chan_lvl  <= chan_meta;
        disc_meta <= disc_in;
        disc_lvl  <= disc_meta;
    end
endmodule

/* psq_sequencer.sv */
module psq_sequencer #(
    parameter int CYC_DIV = psq_pkg::PSQ_CYC_DIV
) (
    input  wire logic        clk,         // core clock, 40 MHz
    input  wire logic        resetn,      // sync reset, active low
    output logic      [11:0] rom_addr,    // program memory address
    input  wire logic [9:0]  rom_data,    // word at rom_addr
    input  wire logic [3:0]  acc,         // accumulator
    input  wire logic [3:0]  breg,        // B register
    input  wire logic        carry,       // carry flag
    input  wire logic [3:0]  yreg,        // Y register
    input  wire logic        alu_flag_we, // ALU updates status
    input  wire logic        alu_flag,    // not-zero/overflow/bit test
    input  wire logic        irq_enable,  // interrupts enabled
    input  wire logic [1:0]  irq_ack,     // clear request flip-flops
    input  wire logic        ext_irq_a,   // async interrupt pin
    input  wire logic        ext_irq_b,   // async interrupt pin
    output logic             cycle_en,    // instruction cycle strobe
    output logic             status,      // status flag
    output logic             ab_load,     // load acc_pat/b_pat
    output logic      [3:0]  acc_pat,     // pattern for accumulator
    output logic      [3:0]  b_pat,       // pattern for B
    output logic      [1:0]  irq_req,     // latched requests
    output logic             irq_take,    // interrupt accepted now
    input  wire logic [15:0] nibble_channel_pins_in,   // pin levels
    output logic      [15:0] nibble_channel_pins_out,  // drive value
    output logic      [15:0] nibble_channel_pins_oe_n, // drive enable
    output logic      [15:0] nibble_channel_lvl,       // synced levels
    input  wire logic [15:0] discrete_pins_in,         // pin levels
    output logic      [15:0] discrete_pins_out,        // drive value
    output logic      [15:0] discrete_pins_oe_n,       // drive enable
    output logic      [15:0] discrete_lvl              // synced levels
);
    localparam int DIV_W = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_DIV - 1);

    if (CYC_DIV < 2)
        $error("CYC_DIV must be at least 2");

    psq_pkg::psq_phase_t phase;
    psq_pkg::psq_phase_t next_phase;

    logic [DIV_W-1:0] div_cnt;
    logic [4:0]       pc_page;
    logic [5:0]       pc_addr;
    logic [4:0]       pend_page;
    logic             page_pend;
    logic [4:0]       next_page;
    logic [5:0]       next_addr;
    logic [4:0]       next_pend_page;
    logic             next_pend;
    logic             next_status;
    logic [11:0]      next_rom;
    logic [5:0]       step_addr;
    logic [4:0]       base_page;
    logic [5:0]       tbl_addr;
    logic [4:0]       tbl_or;
    logic             op_jump;
    logic             op_page;
    logic             op_pat;
    logic             op_tbl;
    logic             op_chan;
    logic             op_disc_y;
    logic             op_disc_n;
    logic             in_exec;
    logic             in_pat;
    logic [1:0]       irq_meta;
    logic [1:0]       irq_sync;

    psq_io_if io_bus ();

    psq_pc_step u_step (
        .cur (pc_addr),
        .nxt (step_addr)
    );

    psq_io_latch u_io (
        .clk       (clk),
        .resetn    (resetn),
        .wr        (io_bus.io),
        .chan_in   (nibble_channel_pins_in),
        .chan_out  (nibble_channel_pins_out),
        .chan_oe_n (nibble_channel_pins_oe_n),
        .chan_lvl  (nibble_channel_lvl),
        .disc_in   (discrete_pins_in),
        .disc_out  (discrete_pins_out),
        .disc_oe_n (discrete_pins_oe_n),
        .disc_lvl  (discrete_lvl)
    );

    // The instruction cycle is a fixed fraction of the core clock.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            div_cnt <= '0;
        else if (div_cnt == DIV_LAST)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    assign cycle_en = (div_cnt == DIV_LAST);
    assign in_exec  = cycle_en && phase == psq_pkg::PSQ_PH_FETCH;
    assign in_pat   = cycle_en && phase == psq_pkg::PSQ_PH_PAT;

    // A ten-bit word is decoded only in the first cycle of an instruction.
    assign op_jump   = rom_data[9:8] == psq_pkg::PSQ_OP_JUMP;
    assign op_page   = rom_data[9:5] == psq_pkg::PSQ_OP_PAGE;
    assign op_pat    = rom_data[9:3] == psq_pkg::PSQ_OP_PAT;
    assign op_tbl    = rom_data[9:2] == psq_pkg::PSQ_OP_TBL;
    assign op_chan   = rom_data[9:2] == psq_pkg::PSQ_OP_CHAN;
    assign op_disc_y = rom_data[9:1] == psq_pkg::PSQ_OP_DISC_Y;
    assign op_disc_n = rom_data[9:3] == psq_pkg::PSQ_OP_DISC_N;

    assign tbl_addr  = {breg[1:0], acc};
    assign tbl_or    = {breg[3:2], carry, rom_data[1:0]};
    assign base_page = page_pend ? pend_page : pc_page;

    always_comb
    begin
        next_phase     = phase;
        next_page      = pc_page;
        next_addr      = pc_addr;
        next_pend      = page_pend;
        next_pend_page = pend_page;
        next_status    = status;
        if (cycle_en)
        begin
            next_page = base_page;
            next_addr = step_addr;
            next_pend = 1'b0;
            case (phase)
                psq_pkg::PSQ_PH_FETCH:
                begin
                    if (alu_flag_we)
                        next_status = alu_flag;
                    if (op_jump)
                    begin
                        next_status = 1'b1;
                        if (status)
                            next_addr = rom_data[5:0];
                    end
                    else if (op_page)
                    begin
                        next_status = status;
                        if (status)
                        begin
                            next_pend      = 1'b1;
                            next_pend_page = rom_data[4:0];
                        end
                    end
                    else if (op_tbl)
                    begin
                        next_status = status;
                        next_addr   = tbl_addr;
                        next_page   = base_page | tbl_or;
                    end
                    else if (op_pat)
                    begin
                        next_status = status;
                        next_addr   = pc_addr;
                        next_phase  = psq_pkg::PSQ_PH_PAT;
                    end
                end
                psq_pkg::PSQ_PH_PAT:
                    next_phase = psq_pkg::PSQ_PH_FETCH;
                default:
                    next_phase = psq_pkg::PSQ_PH_FETCH;
            endcase
        end
    end

    // Only the second cycle of a pattern fetch may leave the program
    // pages; bit 5 of the page then selects the pattern region.
    // The address is set only on the strobe and then held, because the
    // word on rom_data during the pattern cycle is a constant, not an
    // instruction, and must not feed back into its own address.
    always_comb
    begin
        if (in_exec && op_pat)
            next_rom = {rom_data[psq_pkg::PSQ_PAT_SEL_BIT],
                        pc_page | tbl_or, tbl_addr};
        else if (cycle_en)
            next_rom = {1'b0, next_page, next_addr};
        else
            next_rom = rom_addr;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            phase     <= psq_pkg::PSQ_PH_FETCH;
            pc_page   <= psq_pkg::PSQ_PAGE_RST;
            pc_addr   <= psq_pkg::PSQ_ADDR_RST;
            pend_page <= psq_pkg::PSQ_PAGE_RST;
            page_pend <= 1'b0;
            rom_addr  <= {1'b0, psq_pkg::PSQ_PAGE_RST, psq_pkg::PSQ_ADDR_RST};
        end
        else
        begin
            phase     <= next_phase;
            pc_page   <= next_page;
            pc_addr   <= next_addr;
            pend_page <= next_pend_page;
            page_pend <= next_pend;
            rom_addr  <= next_rom;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            status <= psq_pkg::PSQ_STATUS_RST;
        else
            status <= next_status;
    end

    // The fetched pattern word is steered by its two command bits.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ab_load <= 1'b0;
            acc_pat <= 4'h0;
            b_pat   <= 4'h0;
        end
        else
        begin
            ab_load <= in_pat && rom_data[psq_pkg::PSQ_CMD_LOW_BIT];
            if (in_pat && rom_data[psq_pkg::PSQ_CMD_LOW_BIT])
            begin
                acc_pat <= rom_data[3:0];
                b_pat   <= rom_data[7:4];
            end
        end
    end

    assign io_bus.pat_we    = in_pat &&
                              rom_data[psq_pkg::PSQ_CMD_HIGH_BIT];
    assign io_bus.pat_data  = rom_data[7:0];
    assign io_bus.chan_we   = in_exec && op_chan;
    assign io_bus.chan_sel  = rom_data[1:0];
    assign io_bus.chan_data = acc;
    assign io_bus.disc_we   = in_exec && (op_disc_y || op_disc_n);
    assign io_bus.disc_idx  = op_disc_y ? yreg
                                        : {2'b00, rom_data[1:0]};
    assign io_bus.disc_val  = op_disc_y ? rom_data[0] : rom_data[2];

    // The pins are not related to clk, so they pass two flip-flops.
    always_ff @(posedge clk)
    begin
        irq_meta <= {ext_irq_b, ext_irq_a};
        irq_sync <= irq_meta;
    end

    // A request arriving while it is acknowledged is kept.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq_req <= 2'b00;
        else
            irq_req <= (irq_req & ~irq_ack) | irq_sync;
    end

    assign irq_take = in_exec && irq_enable && (|irq_req);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_STEP: assert property (in_exec && !op_jump && !op_tbl && !op_pat
        |=> pc_addr == psq_pkg::PSQ_PC_NEXT[$past(pc_addr)])
        else $error("address counter left its sequence");
    AST_PAGE_HOLD: assert property (!$stable(pc_page) |-> $past(cycle_en))
        else $error("page changed outside an instruction cycle");
    AST_PAT_TWO: assert property (in_exec && op_pat
        |=> phase == psq_pkg::PSQ_PH_PAT [*4] ##1
            phase == psq_pkg::PSQ_PH_FETCH)
        else $error("pattern fetch did not last two cycles");
    AST_PAT_PC: assert property (in_exec && op_pat
        |=> $stable(pc_addr) [*4])
        else $error("pattern fetch moved the program counter");
    AST_IRQ_BLOCK: assert property (phase == psq_pkg::PSQ_PH_PAT
        |-> !irq_take)
        else $error("interrupt accepted in pattern second cycle");
    AST_JUMP: assert property (in_exec && op_jump && status
        |=> pc_addr == $past(rom_data[5:0]) && status)
        else $error("taken jump missed its target");
    AST_SKIP: assert property (in_exec && op_jump && !status
        |=> status && pc_addr == psq_pkg::PSQ_PC_NEXT[$past(pc_addr)])
        else $error("skipped jump did not set status");
    AST_LPU_LATE: assert property (in_exec && op_page && status
        && !page_pend |=> $stable(pc_page) [*4] ##1
            pc_page == $past(rom_data[4:0], 5))
        else $error("page load not one cycle late");
    AST_LPU_SKIP: assert property (in_exec && op_page && !status
        |=> !status && !page_pend)
        else $error("skipped page load changed status");
    AST_TBL: assert property (in_exec && op_tbl
        |=> status == $past(status) && pc_addr == $past(tbl_addr))
        else $error("table jump wrong address or status");
    AST_FETCH_PROG: assert property (phase == psq_pkg::PSQ_PH_FETCH
        |-> !rom_addr[11])
        else $error("instruction fetched outside program pages");
    // A moving address between strobes would hand the wrong word over.
    AST_ROM_HOLD: assert property (!cycle_en
        |=> $stable(rom_addr))
        else $error("program memory address moved inside a cycle");
    AST_IRQ_LATCH: assert property (|irq_sync
        |=> |irq_req)
        else $error("interrupt request was not latched");

    COV_JUMP: cover property (in_exec && op_jump && status);
    COV_PAT: cover property (in_pat && rom_data[9] && rom_data[8]);
    COV_LONG: cover property (in_exec && op_page && status
        ##4 in_exec && op_jump);
    COV_IRQ: cover property (irq_take);
    COV_TBL: cover property (in_exec && op_tbl);
endmodule

/* psq_rom_model.sv */
module psq_rom_model (
    input  wire logic [11:0] addr, // word address from the sequencer
    output logic      [9:0]  data  // word stored at addr
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] mem [4096];

    // Unwritten words read as zero, an encoding the sequencer ignores.
    initial
    begin
        foreach (mem[i]) mem[i] = 10'h000;
    end

    // Pages 32 and up are the pattern region, never an instruction fetch target.
    assign data = mem[addr];
endmodule

/* psq_sequencer_bench.sv */
module psq_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        resetn;
    logic [11:0] rom_addr;
    logic [11:0] exp_a;
    logic [9:0]  rom_data;
    logic [5:0]  e;
    logic [2:0]  p;
    logic [3:0]  acc, breg, yreg, acc_pat, b_pat;
    logic        carry, alu_flag_we, alu_flag, irq_enable, took, ab_seen;
    logic        ext_irq_a, ext_irq_b, cycle_en, status, ab_load, irq_take;
    logic [1:0]  irq_ack, irq_req;
    logic [15:0] ch_out, ch_oe_n, ch_lvl, d_out, d_oe_n, d_lvl;
    int          n_errors, samples_checked, cycles;

    always #12.5 clk = ~clk;

    psq_rom_model i_psq_rom_model (.addr(rom_addr), .data(rom_data));

    // Open-drain pins with pull-ups: the level is low only where driven.
    // The board keeps the factory test input inactive, so the block has
    // no such input and always runs in normal operation.
    psq_sequencer #(.CYC_DIV(4)) i_psq_sequencer (
        .clk(clk), .resetn(resetn), .rom_addr(rom_addr),
        .rom_data(rom_data), .acc(acc), .breg(breg), .carry(carry),
        .yreg(yreg), .alu_flag_we(alu_flag_we), .alu_flag(alu_flag),
        .irq_enable(irq_enable), .irq_ack(irq_ack),
        .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
        .cycle_en(cycle_en), .status(status), .ab_load(ab_load),
        .acc_pat(acc_pat), .b_pat(b_pat), .irq_req(irq_req),
        .irq_take(irq_take), .nibble_channel_pins_in(ch_oe_n),
        .nibble_channel_pins_out(ch_out),
        .nibble_channel_pins_oe_n(ch_oe_n), .nibble_channel_lvl(ch_lvl),
        .discrete_pins_in(d_oe_n), .discrete_pins_out(d_out),
        .discrete_pins_oe_n(d_oe_n), .discrete_lvl(d_lvl));

    task automatic summarize();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got,
                     exp);
        end
    endtask

    // Independent model of the in-page counter's successor.
    function automatic logic [5:0] succ(input logic [5:0] a);
        return {a[4:0], ~(a[5] ^ a[4]) ^ (a[4:0] == 5'h1F)};
    endfunction

    task automatic put(input logic [11:0] a, input logic [9:0] w);
        i_psq_rom_model.mem[a] = w;
    endtask

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        foreach (i_psq_rom_model.mem[i]) i_psq_rom_model.mem[i] = 10'h000;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
    endtask

    // One instruction cycle; ends settled just after the taking edge.
    task automatic step(input logic we, input logic fl);
        @(posedge clk);
        alu_flag_we <= we;
        alu_flag <= fl;
        do @(negedge clk); while (cycle_en !== 1'b1);
        took = irq_take;
        @(posedge clk);
        @(negedge clk);
    endtask

    // Sized from the scenario list with a wide margin.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("ERROR %0t run did not complete", $time);
            summarize();
        end
    end

    initial
    begin
        resetn = 1'b0;
        {acc, breg, yreg, carry, alu_flag_we, alu_flag} = '0;
        {irq_enable, ext_irq_a, ext_irq_b, irq_ack} = '0;
        do_reset();
        e = 6'h3F;
        for (int i = 0; i < 64; i++)
        begin
            step(1'b0, 1'b0);
            e = succ(e);
            chk(16'(rom_addr), {10'h000, e}, "address step");
        end
        chk(16'(rom_addr), 16'h003F, "sequence wrap");

        do_reset();
        put(12'h03E, 10'h305);
        put(12'h03D, 10'h310);
        step(1'b1, 1'b0);
        chk(16'(status), 16'h0000, "alu status");
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h003D, "skipped jump");
        chk(16'(status), 16'h0001, "status after skip");
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h0010, "taken jump");

        do_reset();
        put(12'h03F, 10'h2C5);
        put(12'h03E, 10'h320);
        put(12'h140, 10'h2C3);
        put(12'h141, 10'h311);
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h003E, "old page kept");
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h0160, "long jump");
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        chk(16'(status), 16'h0000, "load skipped");
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h0143, "page unchanged");
        chk(16'(status), 16'h0001, "status after skip");

        do_reset();
        acc <= 4'h9;
        breg <= 4'hE;
        carry <= 1'b1;
        put(12'h03E, 10'h289);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        chk(16'(rom_addr), 16'h0769, "table jump");
        chk(16'(status), 16'h0000, "table status");

        for (int m = 1; m < 4; m++)
        begin
            do_reset();
            irq_enable <= 1'b1;
            ext_irq_a <= 1'b1;
            ext_irq_b <= 1'b1;
            acc <= 4'h3;
            breg <= 4'h6;
            carry <= 1'b0;
            p = (m == 1) ? 3'h1 : 3'(m + 4);
            exp_a = {p[2], 3'b010, p[1:0], 6'h23};
            ab_seen = 1'b0;
            put(12'h03F, {7'b1010000, p});
            put(exp_a, {2'(m), 8'h6B});
            step(1'b0, 1'b0);
            chk(16'(rom_addr), 16'(exp_a), "pattern address");
            step(1'b0, 1'b0);
            chk(16'(took), 16'h0000, "irq in pattern");
            chk(16'(rom_addr), 16'h003E, "pc after pattern");
            repeat (2)
            begin
                if (ab_load === 1'b1)
                begin
                    ab_seen = 1'b1;
                    chk({8'h00, b_pat, acc_pat}, 16'h006B, "pat A/B");
                end
                @(negedge clk);
            end
            chk(16'(ab_seen), 16'(m[0]), "A/B load");
            chk(ch_out, m[1] ? 16'hB6FF : 16'hFFFF, "R2/R3 load");
            step(1'b0, 1'b0);
            chk(16'(took), 16'h0001, "irq after pattern");
            chk(16'(irq_req), 16'h0003, "irq latched");
        end

        do_reset();
        acc <= 4'h5;
        yreg <= 4'h9;
        put(12'h03F, 10'h292);
        put(12'h03E, 10'h294);
        put(12'h03D, 10'h29B);
        repeat (3) step(1'b0, 1'b0);
        repeat (2) @(negedge clk);
        chk(ch_out, 16'hF5FF, "channel write");
        chk(ch_oe_n, 16'hF5FF, "channel drive");
        chk(d_out, 16'hFDF7, "discrete write");
        repeat (3) @(negedge clk);
        chk(ch_lvl, 16'hF5FF, "channel level");
        chk(d_lvl, 16'hFDF7, "discrete level");
        summarize();
    end
endmodule
